// *** csr_pkg.sv ***
// constants and carriers for the clock synchronizer register bank
package csr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [6:0] A_IDENT     = 7'h00;
  localparam logic [6:0] A_PIN_OVR   = 7'h01;
  localparam logic [6:0] A_FAIL_EV   = 7'h02;
  localparam logic [6:0] A_LOOP_EV   = 7'h03;
  localparam logic [6:0] A_MON0      = 7'h05;
  localparam logic [6:0] A_MON1      = 7'h06;
  localparam logic [6:0] A_FAIL_GATE = 7'h09;
  localparam logic [6:0] A_LOOP_GATE = 7'h0A;
  localparam logic [6:0] A_MGATE0    = 7'h0C;
  localparam logic [6:0] A_MGATE1    = 7'h0D;
  localparam logic [6:0] A_FREQ0     = 7'h10;
  localparam logic [6:0] A_FREQ1     = 7'h11;
  localparam logic [6:0] A_FRAME0    = 7'h14;
  localparam logic [6:0] A_FRAME1    = 7'h15;
  localparam logic [6:0] A_RANGE0    = 7'h16;
  localparam logic [6:0] A_RANGE1    = 7'h17;
  localparam logic [6:0] A_SOAK_GATE = 7'h1A;
  localparam logic [6:0] A_SOAK_TIME = 7'h1C;
  localparam logic [6:0] A_FILTER    = 7'h1D;
  localparam logic [6:0] A_HOLDOVER  = 7'h1E;
  localparam logic [6:0] A_OPSEL     = 7'h1F;
  localparam logic [6:0] A_CHOICE    = 7'h20;
  localparam logic [6:0] A_SW_GATE   = 7'h21;
  localparam logic [6:0] A_RESTORE   = 7'h22;
  localparam logic [6:0] A_REVERT    = 7'h23;
  localparam logic [6:0] A_RANK0     = 7'h24;
  localparam logic [6:0] A_RANK1     = 7'h25;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0]  R_ZERO     = 8'h00;
  localparam logic [7:0]  R_ONES     = 8'hFF;
  localparam logic [15:0] R_ONES16   = 16'hFFFF;
  localparam logic [7:0]  R_LOOP_EV  = 8'h70;
  localparam logic [7:0]  R_FRAME0   = 8'hEE;
  localparam logic [7:0]  R_FRAME1   = 8'h0E;
  localparam logic [7:0]  R_RANGE    = 8'h33;
  localparam logic [7:0]  R_SOAK_T   = 8'h1A;
  localparam logic [7:0]  R_SW_GATE  = 8'h3C;
  localparam logic [7:0]  R_RANK0    = 8'h10;
  localparam logic [7:0]  R_RANK1    = 8'h32;
  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int          IDENT_RDY_BIT = 7;
  localparam int          OVR_MODE_BIT  = 0;
  localparam int          OVR_SEL_BIT   = 1;
  localparam logic [1:0]  MODE_MANUAL   = 2'h1;
  localparam int          NIB           = 4;
  // spi frame: command byte {read, addr[6:0]} then one data byte
  localparam int          CMD_LAST      = 7;
  localparam int          FRAME_LAST    = 15;
  localparam int          RD_LOAD_CNT   = 8;
  // pin sync vector {sclk, cs_n, mosi, mode, sel[1:0]}
  localparam logic [5:0]  PIN_RST       = 6'h10;
  // ----------------------------------------
  // monitor timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CFM_WINDOW_NS  = 30000;
  localparam int CFM_WINDOW_CYC = CFM_WINDOW_NS / CLK_PERIOD_NS;
  localparam int SCM_SHIFT      = 1;
  localparam int CFM_PCT        = 3;
  localparam int CFM_DEN        = 100;

  typedef enum logic [1:0] {
    CSR_IDLE = 2'b00,
    CSR_CMD  = 2'b01,
    CSR_DATA = 2'b10,
    CSR_DONE = 2'b11
  } csr_spi_t;

  typedef struct packed {
    logic [7:0] pin_ovr;
    logic [7:0] range0;
    logic [7:0] range1;
    logic [7:0] soak_gate;
    logic [7:0] soak_time;
    logic [7:0] filter;
    logic [7:0] holdover;
    logic [7:0] opsel;
    logic [7:0] sw_gate;
    logic [7:0] restore;
    logic [7:0] revert;
    logic [7:0] rank0;
    logic [7:0] rank1;
  } csr_cfg_t;

  typedef struct packed {
    logic [7:0] freq0;
    logic [7:0] freq1;
    logic [7:0] frame0;
    logic [7:0] frame1;
  } csr_found_t;
endpackage

// *** csr_spi_host.sv ***
// spi host model issuing one register frame at a time
`timescale 1ns/1ns
`default_nettype none
module csr_spi_host (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output var  logic sclk_out,
  output var  logic cs_n_out,
  output var  logic mosi_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // ----------------------------------------
  // frame: command byte then data byte
  // ----------------------------------------
  // any 7-bit address, mapped or not
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    @(posedge clk_in) cs_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (8) @(posedge clk_in);
      mosi_out <= f[i];
      // slow phases: pins pass a 3-stage synchroniser
      repeat (8) @(posedge clk_in);
      sclk_out <= 1'b1;
      q = {q[6:0], miso_in};
      repeat (8) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
    cs_n_out <= 1'b1;
    // released line must not keep its last bit
    mosi_out <= ~mosi_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** csr_top.sv ***
// spi register bank and reference monitors of the clock synchronizer
// Notes on behaviour
// - host configures and reads every register through the spi serial port.
// - automatic or manual operation; manual lets the host pick the reference.
// - offset 00 reads identity code plus a reset-finished ready flag.
// - offset 01, reset zero, hands chosen functions to hardware pins.
// - failure event register read only, resets ones; mask resetting zero gates it.
// - loop event bits sticky, reset 70; mask resetting zero gates them.
// - two sticky monitor failure registers reset to ones: refs 0-1, ref 2.
// - two mask registers reset to ones mask each monitor failure indicator.
// - read-only detected frequency status per reference, resetting to ones.
// - read-only sync frequency and status, reset EE and 0E.
// - out-of-range limit registers reset 33 for refs 0-1 and ref 2.
// - soak timer input mask, reset ones, for all three references.
// - soak timer qualify and disqualify time register, resetting to 1A.
// - filter control holds slope limit, bandwidth and hitless enable.
// - holdover control holds update time, filter, offset and revert enables.
// - operating select register chooses the loop mode.
// - reference choice: host's pick when manual, current selection otherwise.
// - switching gate, reset 3C, picks failures driving switching and holdover.
// - restore wait register, resetting zero, before a failed reference returns.
// - per-reference revertive enables, resetting zero.
// - priority registers reset 10 for refs 0-1 and 32 for ref 2.
// - single-cycle failure when measured period deviates over half of nominal.
// - coarse failure when 30 us edge count changes over three percent.
`timescale 1ns/1ns
`default_nettype none
module csr_top #(
  parameter int         NREF     = 3,
  parameter logic [6:0] ID_CODE  = 7'h5C,  // arbitrary value
  parameter logic [7:0] R_FILTER = 8'h00,
  parameter logic [7:0] R_HOLD   = 8'h00,
  parameter logic [7:0] R_OPSEL  = 8'h00
) (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      spi_sclk_in,
  input  wire logic                      spi_cs_n_in,
  input  wire logic                      spi_mosi_in,
  output var  logic                      spi_miso_out,
  output var  logic                      spi_miso_oe_out,
  input  wire logic                      pin_manual_in,
  input  wire logic [1:0]                pin_choice_in,
  input  wire logic [NREF-1:0]           ref_edge_in,
  input  wire logic [NREF-1:0][15:0]     ref_period_nom_in,
  input  wire logic [NREF-1:0]           pfm_fail_in,
  input  wire logic [NREF-1:0]           gst_fail_in,
  input  wire csr_pkg::csr_found_t       found_in,
  input  wire logic [7:0]                loop_evt_in,
  input  wire logic [1:0]                auto_choice_in,
  output var  csr_pkg::csr_cfg_t         cfg_out,
  output var  logic                      manual_mode_out,
  output var  logic [1:0]                ref_choice_out,
  output var  logic [2*NREF-1:0]         gst_feed_out,
  output var  logic [NREF-1:0]           switch_fail_out,
  output var  logic [NREF-1:0]           holdover_fail_out,
  output var  logic                      irq_out
);
  import csr_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] s1_ff, s2_ff, s3_ff, flt_ff;
  logic       sclk_old_ff;
  wire  [5:0] pins_raw = {spi_sclk_in, spi_cs_n_in, spi_mosi_in, pin_manual_in, pin_choice_in};
  wire  [5:0] agree    = ~(s2_ff ^ s3_ff);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_ff       <= PIN_RST;
      s2_ff       <= PIN_RST;
      s3_ff       <= PIN_RST;
      flt_ff      <= PIN_RST;
      sclk_old_ff <= 1'b0;
    end else begin
      s1_ff       <= pins_raw;
      s2_ff       <= s1_ff;
      s3_ff       <= s2_ff;
      // a change only counts once two stages agree
      flt_ff      <= (s3_ff & agree) | (flt_ff & ~agree);
      sclk_old_ff <= flt_ff[5];
    end
  end

  wire       sclk_f   = flt_ff[5];
  wire       cs_act   = ~flt_ff[4];
  wire       mosi_f   = flt_ff[3];
  wire       pin_man  = flt_ff[2];
  wire [1:0] pin_sel  = flt_ff[1:0];
  wire       sck_rise = sclk_f & ~sclk_old_ff;
  wire       sck_fall = ~sclk_f & sclk_old_ff;

  // ----------------------------------------
  // spi slave
  // ----------------------------------------
  csr_spi_t   st_ff;
  logic [3:0] cnt_ff;
  logic [6:0] sh_ff;
  logic [6:0] addr_ff;
  logic       rd_ff;
  logic [7:0] mo_ff;
  logic       oe_ff;
  logic [7:0] rdata;
  wire  [7:0] in_byte  = {sh_ff, mosi_f};
  wire        cmd_done = (st_ff == CSR_CMD) && sck_rise && (cnt_ff == 4'(CMD_LAST));
  wire        rd_load  = (st_ff == CSR_DATA) && sck_fall && rd_ff && (cnt_ff == 4'(RD_LOAD_CNT));
  wire        wr_stb   = (st_ff == CSR_DATA) && sck_rise && !rd_ff
                         && (cnt_ff == 4'(FRAME_LAST));
  wire        rd_clr   = rd_load;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= CSR_IDLE;
    end else if (!cs_act) begin
      st_ff <= CSR_IDLE;
    end else begin
      unique case (st_ff)
        CSR_IDLE: st_ff <= CSR_CMD;
        CSR_CMD:  if (cmd_done) st_ff <= CSR_DATA;
        CSR_DATA: if (sck_rise && cnt_ff == 4'(FRAME_LAST)) st_ff <= CSR_DONE;
        CSR_DONE: st_ff <= CSR_DONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff  <= 4'h0;
      sh_ff   <= 7'h00;
      addr_ff <= 7'h00;
      rd_ff   <= 1'b0;
    end else if (st_ff == CSR_IDLE) begin
      cnt_ff <= 4'h0;
    end else if (sck_rise && st_ff != CSR_DONE) begin
      cnt_ff <= cnt_ff + 4'h1;
      sh_ff  <= in_byte[6:0];
      if (cmd_done) begin
        rd_ff   <= in_byte[7];
        addr_ff <= in_byte[6:0];
      end
    end
  end

  // miso changes on falling sclk so the host samples on rising
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mo_ff <= 8'h00;
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= cs_act && rd_ff && (st_ff == CSR_DATA);
      if (rd_load) begin
        mo_ff <= rdata;
      end else if (sck_fall && st_ff == CSR_DATA) begin
        mo_ff <= {mo_ff[6:0], 1'b0};
      end
    end
  end
  assign spi_miso_out    = mo_ff[7];
  assign spi_miso_oe_out = oe_ff;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  csr_cfg_t   cfg_ff;
  logic [7:0] fgate_ff, lgate_ff, choice_ff;
  logic [15:0] mgate_ff;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_ff.pin_ovr   <= R_ZERO;
      cfg_ff.range0    <= R_RANGE;
      cfg_ff.range1    <= R_RANGE;
      cfg_ff.soak_gate <= R_ONES;
      cfg_ff.soak_time <= R_SOAK_T;
      cfg_ff.filter    <= R_FILTER;
      cfg_ff.holdover  <= R_HOLD;
      cfg_ff.opsel     <= R_OPSEL;
      cfg_ff.sw_gate   <= R_SW_GATE;
      cfg_ff.restore   <= R_ZERO;
      cfg_ff.revert    <= R_ZERO;
      cfg_ff.rank0     <= R_RANK0;
      cfg_ff.rank1     <= R_RANK1;
      fgate_ff         <= R_ZERO;
      lgate_ff         <= R_ZERO;
      mgate_ff         <= R_ONES16;
      choice_ff        <= R_ZERO;
    end else if (wr_stb) begin
      case (addr_ff)
        A_PIN_OVR:   cfg_ff.pin_ovr   <= in_byte;
        A_RANGE0:    cfg_ff.range0    <= in_byte;
        A_RANGE1:    cfg_ff.range1    <= in_byte;
        A_SOAK_GATE: cfg_ff.soak_gate <= in_byte;
        A_SOAK_TIME: cfg_ff.soak_time <= in_byte;
        A_FILTER:    cfg_ff.filter    <= in_byte;
        A_HOLDOVER:  cfg_ff.holdover  <= in_byte;
        A_OPSEL:     cfg_ff.opsel     <= in_byte;
        A_SW_GATE:   cfg_ff.sw_gate   <= in_byte;
        A_RESTORE:   cfg_ff.restore   <= in_byte;
        A_REVERT:    cfg_ff.revert    <= in_byte;
        A_RANK0:     cfg_ff.rank0     <= in_byte;
        A_RANK1:     cfg_ff.rank1     <= in_byte;
        A_FAIL_GATE: fgate_ff         <= in_byte;
        A_LOOP_GATE: lgate_ff         <= in_byte;
        A_MGATE0:    mgate_ff[7:0]    <= in_byte;
        A_MGATE1:    mgate_ff[15:8]   <= in_byte;
        A_CHOICE:    choice_ff        <= in_byte;
        default:     cfg_ff.pin_ovr   <= cfg_ff.pin_ovr;
      endcase
    end
  end
  assign cfg_out = cfg_ff;

  // ----------------------------------------
  // reference monitors
  // ----------------------------------------
  logic [11:0]       win_ff;
  logic [NREF-1:0]   scm_ff, cfm_ff;
  wire               win_end = (win_ff == 12'(CFM_WINDOW_CYC - 1));

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      win_ff <= 12'h000;
    end else begin
      win_ff <= win_end ? 12'h000 : win_ff + 12'h001;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NREF; gi++) begin : g_mon
      logic [15:0] per_ff, ecnt_ff, prev_ff;
      wire  [16:0] nom   = {1'b0, ref_period_nom_in[gi]};
      wire  [16:0] half  = nom >> SCM_SHIFT;
      wire  [16:0] per   = {1'b0, per_ff};
      wire  [16:0] dev   = (per > nom) ? per - nom : nom - per;
      wire  [15:0] dcnt  = (ecnt_ff > prev_ff) ? ecnt_ff - prev_ff : prev_ff - ecnt_ff;
      wire  [23:0] lhs   = 24'(dcnt) * 24'(CFM_DEN);
      wire  [23:0] rhs   = 24'(prev_ff) * 24'(CFM_PCT);

      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          per_ff     <= 16'h0000;
          scm_ff[gi] <= 1'b0;
        end else if (ref_edge_in[gi]) begin
          per_ff     <= 16'h0001;
          scm_ff[gi] <= dev > half;
        end else begin
          per_ff <= (per_ff == 16'hFFFF) ? per_ff : per_ff + 16'h0001;
          // a missing edge shows as an overlong period
          if (per > nom + half) scm_ff[gi] <= 1'b1;
        end
      end

      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          ecnt_ff    <= 16'h0000;
          prev_ff    <= 16'h0000;
          cfm_ff[gi] <= 1'b0;
        end else if (win_end) begin
          ecnt_ff    <= 16'(ref_edge_in[gi]);
          prev_ff    <= ecnt_ff;
          // window-to-window change check
          // first window after reset has no earlier count to compare
          cfm_ff[gi] <= (prev_ff != 16'h0000) && (lhs > rhs);
        end else if (ref_edge_in[gi]) begin
          ecnt_ff <= ecnt_ff + 16'h0001;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // failure routing
  // ----------------------------------------
  logic [15:0]     fvec;
  logic [7:0]      fail_ev_ff;
  logic [15:0]     mon_ff;
  logic [2*NREF-1:0] gst_ff;
  logic [NREF-1:0] sw_ff, ho_ff;

  always_comb begin
    fvec = 16'h0000;
    for (int i = 0; i < NREF; i++) begin
      fvec[NIB*i +: NIB] = {gst_fail_in[i], pfm_fail_in[i], cfm_ff[i], scm_ff[i]};
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fail_ev_ff <= R_ONES;
      mon_ff     <= R_ONES16;
      gst_ff     <= '0;
      sw_ff      <= '0;
      ho_ff      <= '0;
    end else begin
      mon_ff[7:0]  <= ((rd_clr && addr_ff == A_MON0) ? R_ZERO : mon_ff[7:0]) | fvec[7:0];
      mon_ff[15:8] <= ((rd_clr && addr_ff == A_MON1) ? R_ZERO : mon_ff[15:8]) | fvec[15:8];
      for (int i = 0; i < NREF; i++) begin
        fail_ev_ff[i] <= |(fvec[NIB*i +: NIB] & ~mgate_ff[NIB*i +: NIB]);
        gst_ff[2*i +: 2] <= {cfm_ff[i], scm_ff[i]} & ~cfg_ff.soak_gate[2*i +: 2];
        sw_ff[i] <= |(fvec[NIB*i +: NIB] & cfg_ff.sw_gate[3:0]);
        ho_ff[i] <= |(fvec[NIB*i +: NIB] & cfg_ff.sw_gate[7:4]);
      end
      for (int i = NREF; i < 8; i++) begin
        fail_ev_ff[i] <= 1'b0;
      end
    end
  end
  assign gst_feed_out      = gst_ff;
  assign switch_fail_out   = sw_ff;
  assign holdover_fail_out = ho_ff;

  // ----------------------------------------
  // loop events, status and interrupt
  // ----------------------------------------
  logic [7:0] loop_ev_ff;
  logic       rdy_ff, irq_ff, man_ff;
  logic [1:0] sel_ff;
  csr_found_t found_ff;
  wire        manual = cfg_ff.pin_ovr[OVR_MODE_BIT] ? pin_man
                                                    : (cfg_ff.opsel[1:0] == MODE_MANUAL);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      loop_ev_ff <= R_LOOP_EV;
      rdy_ff     <= 1'b0;
      irq_ff     <= 1'b0;
      man_ff     <= 1'b0;
      sel_ff     <= 2'h0;
      found_ff   <= {R_ONES, R_ONES, R_FRAME0, R_FRAME1};
    end else begin
      loop_ev_ff <= ((rd_clr && addr_ff == A_LOOP_EV) ? R_ZERO : loop_ev_ff) | loop_evt_in;
      rdy_ff     <= 1'b1;
      irq_ff     <= |(fail_ev_ff & fgate_ff) | |(loop_ev_ff & lgate_ff);
      man_ff     <= manual;
      sel_ff     <= !manual ? auto_choice_in
                  : cfg_ff.pin_ovr[OVR_SEL_BIT] ? pin_sel : choice_ff[1:0];
      found_ff   <= found_in;
    end
  end
  assign irq_out         = irq_ff;
  assign manual_mode_out = man_ff;
  assign ref_choice_out  = sel_ff;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rdata = R_ZERO;
    case (addr_ff)
      A_IDENT:     rdata = {rdy_ff, ID_CODE};
      A_PIN_OVR:   rdata = cfg_ff.pin_ovr;
      A_FAIL_EV:   rdata = fail_ev_ff;
      A_LOOP_EV:   rdata = loop_ev_ff;
      A_MON0:      rdata = mon_ff[7:0];
      A_MON1:      rdata = mon_ff[15:8];
      A_FAIL_GATE: rdata = fgate_ff;
      A_LOOP_GATE: rdata = lgate_ff;
      A_MGATE0:    rdata = mgate_ff[7:0];
      A_MGATE1:    rdata = mgate_ff[15:8];
      A_FREQ0:     rdata = found_ff.freq0;
      A_FREQ1:     rdata = found_ff.freq1;
      A_FRAME0:    rdata = found_ff.frame0;
      A_FRAME1:    rdata = found_ff.frame1;
      A_RANGE0:    rdata = cfg_ff.range0;
      A_RANGE1:    rdata = cfg_ff.range1;
      A_SOAK_GATE: rdata = cfg_ff.soak_gate;
      A_SOAK_TIME: rdata = cfg_ff.soak_time;
      A_FILTER:    rdata = cfg_ff.filter;
      A_HOLDOVER:  rdata = cfg_ff.holdover;
      A_OPSEL:     rdata = cfg_ff.opsel;
      A_CHOICE:    rdata = man_ff ? choice_ff : {6'h00, sel_ff};
      A_SW_GATE:   rdata = cfg_ff.sw_gate;
      A_RESTORE:   rdata = cfg_ff.restore;
      A_REVERT:    rdata = cfg_ff.revert;
      A_RANK0:     rdata = cfg_ff.rank0;
      A_RANK1:     rdata = cfg_ff.rank1;
      default:     rdata = R_ZERO;
    endcase
  end
endmodule
`default_nettype wire

// *** csr_top_props.sv ***
// port assertions for the register bank
`timescale 1ns/1ns
`default_nettype none
module csr_top_props
  import csr_pkg::*;
#(
  parameter int NREF = 3
) (
  input wire logic              ref_clk_in,
  input wire logic              rst_in,
  input wire logic              spi_cs_n_in,
  input wire logic              spi_miso_oe_out,
  input wire logic              pin_manual_in,
  input wire logic [1:0]        pin_choice_in,
  input wire logic [NREF-1:0]   pfm_fail_in,
  input wire logic [NREF-1:0]   gst_fail_in,
  input wire logic [1:0]        auto_choice_in,
  input wire csr_pkg::csr_cfg_t cfg_out,
  input wire logic              manual_mode_out,
  input wire logic [1:0]        ref_choice_out,
  input wire logic [2*NREF-1:0] gst_feed_out,
  input wire logic [NREF-1:0]   switch_fail_out,
  input wire logic [NREF-1:0]   holdover_fail_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_oe_idle: assert property (spi_cs_n_in [*8] |=> !spi_miso_oe_out)
    else $error("miso enable outside frame");
  a_mode_reg: assert property ((
    !cfg_out.pin_ovr[OVR_MODE_BIT] && cfg_out.opsel[1:0] == MODE_MANUAL) [*3] |-> manual_mode_out)
    else $error("manual mode not taken");
  a_mode_pin: assert property ((cfg_out.pin_ovr[OVR_MODE_BIT] && $stable(pin_manual_in)) [*8]
    |-> manual_mode_out == pin_manual_in) else $error("mode pin ignored");
  a_choice_auto: assert property ((!manual_mode_out && $stable(auto_choice_in)) [*3]
    |-> ref_choice_out == auto_choice_in) else $error("auto choice wrong");
  a_choice_pin: assert property ((
    manual_mode_out && cfg_out.pin_ovr[OVR_SEL_BIT] && $stable(pin_choice_in)) [*8]
    |-> ref_choice_out == pin_choice_in) else $error("choice pin ignored");
  a_switch_gate: assert property ((pfm_fail_in[1] && cfg_out.sw_gate[2]) [*3]
    |-> switch_fail_out[1]) else $error("switch fail missing");
  a_hold_gate: assert property ((gst_fail_in[2] && cfg_out.sw_gate[7]) [*3]
    |-> holdover_fail_out[2]) else $error("holdover fail missing");
  a_soak_gate: assert property ((cfg_out.soak_gate[2*NREF-1:0] == '1) [*2]
    |-> gst_feed_out == '0) else $error("soak feed not masked");
endmodule
bind csr_top csr_top_props #(.NREF(NREF)) u_props (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_miso_oe_out(spi_miso_oe_out), .pin_manual_in(pin_manual_in),
  .pin_choice_in(pin_choice_in), .pfm_fail_in(pfm_fail_in), .gst_fail_in(gst_fail_in),
  .auto_choice_in(auto_choice_in), .cfg_out(cfg_out), .manual_mode_out(manual_mode_out),
  .ref_choice_out(ref_choice_out), .gst_feed_out(gst_feed_out),
  .switch_fail_out(switch_fail_out), .holdover_fail_out(holdover_fail_out));
`default_nettype wire

// *** csr_top_tb_top.sv ***
// self-checking bench for the register bank
`timescale 1ns/1ns
`default_nettype none
module csr_top_tb_top;
  import csr_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       rst_in     = 1'b1;
  logic       sclk, cs_n, mosi, miso, oe, mm, irq;
  logic       man        = 1'b0;
  logic [1:0] pch        = 2'h0;
  logic [1:0] ach        = 2'h0;
  logic [1:0] ch;
  logic [2:0] edg        = 3'h0;
  logic [2:0] precise_frequency_check        = 3'h0;
  logic [2:0] gst        = 3'h0;
  logic [2:0] sw, ho;
  logic [7:0] lev        = 8'h00;
  logic [7:0] q;
  logic [5:0] feed;
  csr_cfg_t   cfg;
  int         failures   = 0;
  int         checks     = 0;
  int         ecnt       = 0;
  wire logic  miso_w     = oe ? miso : ~miso;
  initial forever #5 ref_clk_in = ~ref_clk_in;
  // edges at the nominal period keep period monitors quiet
  always @(posedge ref_clk_in) begin
    ecnt <= (ecnt == 19) ? 0 : ecnt + 1;
    edg  <= (ecnt == 19) ? 3'h7 : 3'h0;
  end
  csr_top dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe), .pin_manual_in(man),
    .pin_choice_in(pch), .ref_edge_in(edg), .ref_period_nom_in({3{16'h0014}}),
    .pfm_fail_in(precise_frequency_check), .gst_fail_in(gst), .found_in(32'hFFFFEE0E), .loop_evt_in(lev),
    .auto_choice_in(ach), .cfg_out(cfg), .manual_mode_out(mm), .ref_choice_out(ch),
    .gst_feed_out(feed), .switch_fail_out(sw), .holdover_fail_out(ho), .irq_out(irq));
  csr_spi_host host (.clk_in(ref_clk_in), .miso_in(miso_w), .sclk_out(sclk), .cs_n_out(cs_n),
    .mosi_out(mosi));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string n);
    host.xfer(1'b1, a, 8'h00, q);
    chk(n, q, e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, q);
  endtask
  task automatic stop_test;
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [15:0] rt [29] = '{16'h00DC, 16'h0100, 16'h0200, 16'h0370, 16'h0400, 16'h05FF,
      16'h06FF, 16'h0900, 16'h0A00, 16'h0CFF, 16'h0DFF, 16'h10FF, 16'h11FF, 16'h14EE,
      16'h150E, 16'h1633, 16'h1733, 16'h1AFF, 16'h1C1A, 16'h1D00, 16'h1E00, 16'h1F00,
      16'h2000, 16'h213C, 16'h2200, 16'h2300, 16'h2410, 16'h2532, 16'h0500};
    foreach (rt[i]) rd(rt[i][14:8], rt[i][7:0], $sformatf("reg_%h", rt[i][15:8]));
  endtask
  task automatic t_rw;
    logic [6:0] wa [11] = '{A_RANGE0, A_RANGE1, A_SOAK_GATE, A_SOAK_TIME, A_FILTER, A_HOLDOVER,
      A_SW_GATE, A_RESTORE, A_REVERT, A_RANK0, A_RANK1};
    foreach (wa[i]) wr(wa[i], 8'hA5 ^ 8'(i));
    foreach (wa[i]) rd(wa[i], 8'hA5 ^ 8'(i), "rw");
    chk("rank1", cfg.rank1, 8'hAF);
    chk("feed", {2'h0, feed & 6'h27}, 8'h00);
    wr(A_IDENT, 8'h00);
    rd(A_IDENT, 8'hDC, "ident");
    wr(A_FREQ0, 8'h00);
    rd(A_FREQ0, 8'hFF, "freq0");
    wr(A_SW_GATE, R_SW_GATE);
  endtask
  task automatic t_events;
    wr(A_LOOP_GATE, 8'hFF);
    lev <= 8'h04;
    @(posedge ref_clk_in) lev <= 8'h00;
    repeat (8) @(posedge ref_clk_in);
    chk("irq", {7'h0, irq}, 8'h01);
    rd(A_LOOP_EV, 8'h04, "loop_ev");
    chk("irq", {7'h0, irq}, 8'h00);
    rd(A_LOOP_EV, 8'h00, "loop_ev");
    wr(A_MGATE0, 8'hBB);
    wr(A_FAIL_GATE, 8'h02);
    precise_frequency_check <= 3'h2;
    rd(A_FAIL_EV, 8'h02, "fail_ev");
    chk("irq", {7'h0, irq}, 8'h01);
    chk("switch", {5'h0, sw}, 8'h02);
    precise_frequency_check <= 3'h0;
    gst <= 3'h4;
    wr(A_SW_GATE, 8'hCC);
    chk("switch", {5'h0, sw}, 8'h04);
    chk("hold", {5'h0, ho}, 8'h04);
    gst <= 3'h0;
    rd(A_FAIL_EV, 8'h00, "fail_ev");
  endtask
  task automatic t_mode;
    wr(A_OPSEL, 8'h01);
    wr(A_CHOICE, 8'h02);
    rd(A_CHOICE, 8'h02, "choice");
    chk("manual", {7'h0, mm}, 8'h01);
    chk("ref", {6'h0, ch}, 8'h02);
    wr(A_OPSEL, 8'h00);
    ach <= 2'h1;
    rd(A_CHOICE, 8'h01, "choice");
    chk("manual", {7'h0, mm}, 8'h00);
    man <= 1'b1;
    pch <= 2'h3;
    wr(A_PIN_OVR, 8'h03);
    chk("manual", {7'h0, mm}, 8'h01);
    chk("ref", {6'h0, ch}, 8'h03);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    t_reset;
    t_rw;
    t_events;
    t_mode;
    stop_test;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    failures++;
    stop_test;
  end
endmodule
`default_nettype wire
